// ### src/sadc_ctrl.sv
// sequencing, registers and bus slave of the 10-bit converter
`timescale 1ns/10ps
module sadc_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   sleep_mode,
  input  wire logic                   rc_tick,
  input  wire logic                   comp_hi,
  input  wire sadc_pkg::sadc_axi_req_t axi_req,
  output sadc_pkg::sadc_axi_rsp_t      axi_rsp,
  output sadc_pkg::sadc_ana_t          ana,
  output logic                        conv_done_flag
);
  import sadc_pkg::*;

  function automatic logic [4:0] div_last(input logic [1:0] sel);
    case (sel)
      CLK_DIV2: div_last = DIV2_LAST;
      CLK_DIV8: div_last = DIV8_LAST;
      default:  div_last = DIV32_LAST;
    endcase
  endfunction

  function automatic logic [7:0] pin_mask(input logic [3:0] cfg);
    case (cfg)
      4'h0, 4'h1, 4'h8:       pin_mask = 8'hFF;
      4'h2, 4'h3, 4'hC:       pin_mask = 8'h1F;
      4'h4, 4'h5:             pin_mask = 8'h0B;
      4'h6, 4'h7:             pin_mask = 8'h00;
      4'h9, 4'hA, 4'hB:       pin_mask = 8'h3F;
      4'hD:                   pin_mask = 8'h0F;
      4'hE:                   pin_mask = 8'h01;
      default:                pin_mask = 8'h0D;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  logic [7:0]  ctrl_main_r;
  logic [7:0]  port_cfg_r;
  logic        done_flag_r;
  sadc_state_t state_r;
  logic [3:0]  tad_r;
  logic [4:0]  div_r;
  logic [9:0]  dac_r;
  logic [9:0]  mask_r;
  logic [9:0]  result_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic        wl0;
  logic        wr_ctrl;
  logic        wr_pcfg;
  logic        wr_done;
  logic        wr_map;
  logic        ar_take;
  logic [1:0]  clk_sel;
  logic        div_hit;
  logic        tad_tick;
  logic        start;
  logic        conv_finish;
  logic [7:0]  res_high;
  logic [7:0]  res_low;
  logic [7:0]  rd_byte;
  logic        rd_map;
  logic [9:0]  dac_nxt;

  // bus side: readies drop with ce so nothing is taken while frozen
  assign axi_rsp.awready = ce && !aw_have_r && !bvalid_r;
  assign axi_rsp.wready  = ce && !w_have_r && !bvalid_r;
  assign axi_rsp.arready = ce && !rvalid_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;

  assign aw_take = axi_req.awvalid && axi_rsp.awready;
  assign w_take  = axi_req.wvalid && axi_rsp.wready;
  assign wr_fire = ce && (aw_have_r || aw_take) && (w_have_r || w_take);
  assign wa  = aw_have_r ? awaddr_r : axi_req.awaddr;
  assign wd  = w_have_r ? wdata_r : axi_req.wdata;
  assign wl0 = w_have_r ? wstrb_r[0] : axi_req.wstrb[0];
  assign wr_map  = hit(wa, CTRL_MAIN_OFS) || hit(wa, PORT_CFG_OFS) ||
                   hit(wa, RES_HIGH_OFS) || hit(wa, RES_LOW_OFS) ||
                   hit(wa, DONE_STAT_OFS);
  assign wr_ctrl = wr_fire && wl0 && hit(wa, CTRL_MAIN_OFS);
  assign wr_pcfg = wr_fire && wl0 && hit(wa, PORT_CFG_OFS);
  assign wr_done = wr_fire && wl0 && hit(wa, DONE_STAT_OFS);
  assign ar_take = axi_req.arvalid && axi_rsp.arready;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_take)
        awaddr_r <= axi_req.awaddr;
      if (w_take)
      begin
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
        aw_have_r <= aw_have_r || aw_take;
        w_have_r  <= w_have_r || w_take;
        if (bvalid_r && axi_req.bready)
          bvalid_r <= 1'b0;
      end
    end
  end

  assign clk_sel = ctrl_main_r[CLK_SEL_HI:CLK_SEL_LO];
  // core divider halts in sleep; only the RC source keeps ticking
  assign div_hit  = !sleep_mode && (div_r == div_last(clk_sel));
  assign tad_tick = (clk_sel == CLK_RC) ? rc_tick : div_hit;
  assign start = wr_ctrl && wd[GO_BIT] && wd[POWER_BIT] &&
                 ctrl_main_r[POWER_BIT] && state_r == SADC_IDLE;
  // a rewrite that keeps go and power must not swallow the last tick
  assign conv_finish = state_r == SADC_CONV && tad_tick &&
                       !(wr_ctrl && !(wd[GO_BIT] && wd[POWER_BIT])) &&
                       tad_r == TAD_CONV_LAST;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= 5'h00;
    else if (ce)
    begin
      if (start || div_hit || clk_sel == CLK_RC)
        div_r <= 5'h00;
      else if (!sleep_mode)
        div_r <= div_r + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_main_r <= CTRL_MAIN_RST;
      port_cfg_r  <= PORT_CFG_RST;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_main_r <= wd[7:0] & CTRL_MAIN_WM;
      if (wr_pcfg)
        port_cfg_r <= wd[7:0] & PORT_CFG_WM;
    end
  end

  // keep the bit when the input sits above the trial level
  assign dac_nxt = (comp_hi ? dac_r : (dac_r & ~mask_r)) | (mask_r >> 1);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= SADC_IDLE;
      tad_r   <= 4'h0;
      dac_r   <= 10'h000;
      mask_r  <= 10'h000;
    end
    else if (ce)
    begin
      case (state_r)
        SADC_IDLE:
          if (start)
          begin
            state_r <= SADC_CONV;
            tad_r   <= 4'h0;
            dac_r   <= 10'h000;
            mask_r  <= 10'h000;
          end
        SADC_CONV:
          if (wr_ctrl && !wd[POWER_BIT])
            state_r <= SADC_IDLE;
          else if (wr_ctrl && !wd[GO_BIT])
          begin
            state_r <= SADC_ABORT;
            tad_r   <= 4'h0;
          end
          else if (tad_tick)
          begin
            if (tad_r == 4'h0)
            begin
              dac_r  <= SAR_MSB;
              mask_r <= SAR_MSB;
              tad_r  <= 4'h1;
            end
            else if (tad_r == TAD_CONV_LAST)
              state_r <= SADC_IDLE;
            else
            begin
              dac_r  <= dac_nxt;
              mask_r <= mask_r >> 1;
              tad_r  <= tad_r + 4'h1;
            end
          end
        SADC_ABORT:
          if (wr_ctrl && !wd[POWER_BIT])
            state_r <= SADC_IDLE;
          else if (tad_tick)
          begin
            if (tad_r == TAD_ABORT_LAST)
              state_r <= SADC_IDLE;
            else
              tad_r <= tad_r + 4'h1;
          end
        default:
          state_r <= SADC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      result_r <= 10'h000;
    else if (ce && conv_finish)
      result_r <= dac_r;
  end

  // a new completion beats a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      done_flag_r <= 1'b0;
    else if (ce)
    begin
      if (conv_finish)
        done_flag_r <= 1'b1;
      else if (wr_done && !wd[DONE_BIT])
        done_flag_r <= 1'b0;
    end
  end

  assign res_high = port_cfg_r[JUSTIFY_BIT] ? {6'h00, result_r[9:8]}
                                            : result_r[9:2];
  assign res_low  = port_cfg_r[JUSTIFY_BIT] ? result_r[7:0]
                                            : {result_r[1:0], 6'h00};

  always_comb
  begin
    rd_map  = 1'b1;
    rd_byte = 8'h00;
    if (hit(axi_req.araddr, CTRL_MAIN_OFS))
      rd_byte = {ctrl_main_r[7:3], state_r == SADC_CONV, 1'b0,
                 ctrl_main_r[POWER_BIT]};
    else if (hit(axi_req.araddr, PORT_CFG_OFS))
      rd_byte = port_cfg_r;
    else if (hit(axi_req.araddr, RES_HIGH_OFS))
      rd_byte = res_high;
    else if (hit(axi_req.araddr, RES_LOW_OFS))
      rd_byte = res_low;
    else if (hit(axi_req.araddr, DONE_STAT_OFS))
      rd_byte = {7'h00, done_flag_r};
    else
      rd_map = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h000000, rd_byte};
        rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && axi_req.rready)
        rvalid_r <= 1'b0;
    end
  end

  // analog front end is steered straight from the register flops
  assign ana.chan         = ctrl_main_r[CHAN_HI:CHAN_LO];
  assign ana.hold_connect = ctrl_main_r[POWER_BIT] && state_r == SADC_IDLE;
  assign ana.dac_code     = dac_r;
  assign ana.analog_mask  = pin_mask(port_cfg_r[PCFG_HI:0]);
  assign ana.vref_pos_pin = VREF_POS_PIN_SET[port_cfg_r[PCFG_HI:0]];
  assign ana.vref_neg_pin = VREF_NEG_PIN_SET[port_cfg_r[PCFG_HI:0]];
  assign ana.power_on     = ctrl_main_r[POWER_BIT];
  assign conv_done_flag   = done_flag_r;

  sequence s_last_tick;
    ce && conv_finish;
  endsequence
  sequence s_idle_done;
    state_r == SADC_IDLE && done_flag_r;
  endsequence

  a_start_go: assert property (@(posedge clk) disable iff (!rst_b)
    ce && start |=> state_r == SADC_CONV && tad_r == 4'h0)
    else $error("go write did not start a conversion");
  a_no_start_off: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl_main_r[POWER_BIT] |-> state_r != SADC_CONV)
    else $error("conversion running while powered off");
  a_done_load: assert property (@(posedge clk) disable iff (!rst_b)
    s_last_tick |=> s_idle_done ##0 result_r == $past(dac_r))
    else $error("completion did not load result and flag");
  a_abort_keep: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SADC_ABORT |=> $stable(result_r))
    else $error("abort changed the result");
  a_conv_span: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SADC_CONV |-> tad_r <= TAD_CONV_LAST)
    else $error("conversion ran past twelve bit periods");
  a_div8_tick: assert property (@(posedge clk) disable iff (!rst_b)
    tad_tick && clk_sel == CLK_DIV8 |-> div_r == 5'h07 && !sleep_mode)
    else $error("divide-by-8 tick at wrong count");
  a_all_analog: assert property (@(posedge clk) disable iff (!rst_b)
    port_cfg_r[PCFG_HI:0] == 4'h0 |-> ana.analog_mask == 8'hFF &&
    !ana.vref_pos_pin && !ana.vref_neg_pin)
    else $error("code zero is not all analog");
  a_justify_fmt: assert property (@(posedge clk) disable iff (!rst_b)
    port_cfg_r[JUSTIFY_BIT] |-> res_high[7:2] == 6'h00)
    else $error("right justified high byte not zero");
  a_sleep_rc: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sleep_mode && clk_sel == CLK_RC && rc_tick && !wr_ctrl &&
    state_r == SADC_CONV |=> tad_r != $past(tad_r) ||
    state_r != SADC_CONV)
    else $error("conversion stalled in sleep");
  a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_b)
    bvalid_r && !axi_req.bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped early");

endmodule

// ### src/sadc_pkg.sv
// shared constants and carrier types for the converter control block
package sadc_pkg;

  localparam logic [7:0] CTRL_MAIN_OFS = 8'h00;
  localparam logic [7:0] PORT_CFG_OFS  = 8'h04;
  localparam logic [7:0] RES_HIGH_OFS  = 8'h08;
  localparam logic [7:0] RES_LOW_OFS   = 8'h0C;
  localparam logic [7:0] DONE_STAT_OFS = 8'h10;

  localparam int CLK_SEL_HI  = 7;
  localparam int CLK_SEL_LO  = 6;
  localparam int CHAN_HI     = 5;
  localparam int CHAN_LO     = 3;
  localparam int GO_BIT      = 2;
  localparam int POWER_BIT   = 0;
  localparam int JUSTIFY_BIT = 5;
  localparam int PCFG_HI     = 3;
  localparam int DONE_BIT    = 0;

  localparam logic [7:0] CTRL_MAIN_RST = 8'h00;
  localparam logic [7:0] PORT_CFG_RST  = 8'h00;
  localparam logic [7:0] CTRL_MAIN_WM  = 8'hF9;
  localparam logic [7:0] PORT_CFG_WM   = 8'h2F;

  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC   = 2'h3;
  localparam logic [4:0] DIV2_LAST  = 5'h01;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  localparam logic [3:0] TAD_CONV_LAST  = 4'hB;
  localparam logic [3:0] TAD_ABORT_LAST = 4'h1;
  localparam logic [9:0] SAR_MSB        = 10'h200;

  localparam logic [15:0] VREF_POS_PIN_SET = 16'hBD2A;
  localparam logic [15:0] VREF_NEG_PIN_SET = 16'hB900;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SADC_IDLE  = 2'b00,
    SADC_CONV  = 2'b01,
    SADC_ABORT = 2'b10
  } sadc_state_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } sadc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sadc_axi_rsp_t;

  typedef struct packed {
    logic [2:0]  chan;
    logic        hold_connect;
    logic [9:0]  dac_code;
    logic [7:0]  analog_mask;
    logic        vref_pos_pin;
    logic        vref_neg_pin;
    logic        power_on;
  } sadc_ana_t;

endpackage

// ### tb/sadc_ana_src.sv
// analog source model driving the converter comparator
`timescale 1ns/10ps
module sadc_ana_src (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire sadc_pkg::sadc_ana_t ana,
  input  wire logic [7:0][9:0]     level_tab,
  output logic                     comp_hi
);
  import sadc_pkg::*;
  logic [9:0] held_r;
  logic       junk_r;
  // hold cap follows the selected pin only while connected
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      held_r <= 10'h000;
    else if (ana.hold_connect && ana.power_on)
      held_r <= level_tab[ana.chan];
  // comparator is meaningless while acquiring: toggle so no value leaks
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      junk_r <= 1'b0;
    else
      junk_r <= ~junk_r;
  assign comp_hi = (ana.hold_connect || !ana.power_on) ? junk_r
                 : (held_r >= ana.dac_code);
endmodule

// ### tb/tb_sadc_ctrl.sv
// testbench for the converter control block
`timescale 1ns/10ps
module tb_sadc_ctrl;
  import sadc_pkg::*;
  logic            clk;
  logic            rst_b;
  logic            ce;
  logic            sleep_mode;
  logic            rc_tick = 1'b0;
  logic            comp_hi;
  logic            conv_done_flag;
  sadc_axi_req_t   req;
  sadc_axi_rsp_t   rsp;
  sadc_ana_t       ana;
  logic [7:0][9:0] level_tab;
  logic [2:0]      rc_cnt = 3'h0;
  logic [31:0]     rd;
  logic [1:0]      rr;
  logic [1:0]      sel;
  logic [2:0]      ch;
  logic [9:0]      r;
  logic [7:0]      ph;
  logic [7:0]      pl;
  time             t0;
  int              n;
  int              error_cnt;
  int              n_tests;
  int              dv [4] = '{2, 8, 32, 5};
  logic [15:0][7:0] mask_tab = {8'h0D, 8'h01, 8'h0F, 8'h1F, 8'h3F, 8'h3F,
    8'h3F, 8'hFF, 8'h00, 8'h00, 8'h0B, 8'h0B, 8'h1F, 8'h1F, 8'hFF, 8'hFF};
  logic [15:0]     pos_tab = 16'hBD2A;
  logic [15:0]     neg_tab = 16'hB900;

  sadc_ctrl uut (
    .clk            (clk),
    .rst_b          (rst_b),
    .ce             (ce),
    .sleep_mode     (sleep_mode),
    .rc_tick        (rc_tick),
    .comp_hi        (comp_hi),
    .axi_req        (req),
    .axi_rsp        (rsp),
    .ana            (ana),
    .conv_done_flag (conv_done_flag)
  );
  sadc_ana_src src (
    .clk       (clk),
    .rst_b     (rst_b),
    .ana       (ana),
    .level_tab (level_tab),
    .comp_hi   (comp_hi)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;
  // rc clock stands in at a fifth of the core rate
  always @(posedge clk)
  begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int t;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    req.bready <= 1'b0;
    chk(32'(t < 50), 32'h1);
    chk({30'h0, rsp.bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
    int t;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    d = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    chk(32'(t < 50), 32'h1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  rs;
    axr(a, d, rs);
    chk(d, {24'h000000, e});
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // bounded wait: a stuck converter must not hang the run
  task automatic wait_done;
    for (int k = 0; k < 2000; k++)
    begin
      @(posedge clk);
      if (conv_done_flag === 1'b1)
        break;
    end
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    sleep_mode = 1'b0;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    for (int i = 0; i < 8; i++)
      level_tab[i] = 10'h0F0;
    // only odd channels converted, extremes included
    level_tab[1] = 10'h3FF;
    level_tab[3] = 10'h000;
    level_tab[5] = 10'h2AA;
    level_tab[7] = 10'h155;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk(32'(ana.analog_mask), 32'hFF);
    rdchk(CTRL_MAIN_OFS, CTRL_MAIN_RST);
    rdchk(PORT_CFG_OFS, PORT_CFG_RST);
    rdchk(DONE_STAT_OFS, 8'h00);
    axr(8'h14, rd, rr);
    chk({rd[31:2], rr}, {30'h0, RESP_SLVERR});
    axw(8'h14, 8'hFF, RESP_SLVERR);
    // power-on write with go must not start
    axw(CTRL_MAIN_OFS, 8'h05, RESP_OKAY);
    rdchk(CTRL_MAIN_OFS, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      ch = 3'(2 * s + 1);
      r = level_tab[ch];
      axw(PORT_CFG_OFS, {2'b00, sel[0], 5'h00}, RESP_OKAY);
      axw(CTRL_MAIN_OFS, {sel, ch, 3'b001}, RESP_OKAY);
      repeat (20) @(posedge clk);
      chk(32'(ana.chan), 32'(ch));
      sleep_mode <= (s == 3);
      axw(CTRL_MAIN_OFS, {sel, ch, 3'b101}, RESP_OKAY);
      t0 = $time;
      rdchk(CTRL_MAIN_OFS, {sel, ch, 3'b101});
      wait_done();
      n = int'(($time - t0) / 10);
      chk(32'(n >= 11 * dv[s] && n <= 12 * dv[s] + 2), 32'h1);
      sleep_mode <= 1'b0;
      rdchk(CTRL_MAIN_OFS, {sel, ch, 3'b001});
      rdchk(DONE_STAT_OFS, 8'h01);
      rdchk(RES_HIGH_OFS, sel[0] ? {6'h00, r[9:8]} : r[9:2]);
      rdchk(RES_LOW_OFS, sel[0] ? r[7:0] : {r[1:0], 6'h00});
      axw(DONE_STAT_OFS, 8'h00, RESP_OKAY);
      chk(32'(conv_done_flag), 32'h0);
    end
    // abort in mid-conversion keeps the old result
    axw(CTRL_MAIN_OFS, 8'hA9, RESP_OKAY);
    repeat (20) @(posedge clk);
    axr(RES_HIGH_OFS, rd, rr);
    ph = rd[7:0];
    axr(RES_LOW_OFS, rd, rr);
    pl = rd[7:0];
    axw(CTRL_MAIN_OFS, 8'hAD, RESP_OKAY);
    repeat (40) @(posedge clk);
    // frozen enable: long enough to finish, so go must still read busy
    ce <= 1'b0;
    repeat (400) @(posedge clk);
    chk(32'(rsp.awready || rsp.arready), 32'h0);
    ce <= 1'b1;
    rdchk(CTRL_MAIN_OFS, 8'hAD);
    axw(CTRL_MAIN_OFS, 8'hA9, RESP_OKAY);
    chk(32'(ana.hold_connect), 32'h0);
    rdchk(CTRL_MAIN_OFS, 8'hA9);
    repeat (80) @(posedge clk);
    chk(32'(ana.hold_connect), 32'h1);
    chk(32'(conv_done_flag), 32'h0);
    rdchk(RES_HIGH_OFS, ph);
    rdchk(RES_LOW_OFS, pl);
    axw(CTRL_MAIN_OFS, 8'h00, RESP_OKAY);
    chk(32'(ana.power_on), 32'h0);
    axw(CTRL_MAIN_OFS, 8'h04, RESP_OKAY);
    rdchk(CTRL_MAIN_OFS, 8'h00);
    repeat (40) @(posedge clk);
    chk(32'(conv_done_flag), 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      axw(PORT_CFG_OFS, 8'(c), RESP_OKAY);
      chk(32'(ana.analog_mask), 32'(mask_tab[c]));
      chk(32'(ana.vref_pos_pin), 32'(pos_tab[c]));
      chk(32'(ana.vref_neg_pin), 32'(neg_tab[c]));
    end
    axw(PORT_CFG_OFS, 8'hFF, RESP_OKAY);
    rdchk(PORT_CFG_OFS, 8'h2F);
    axw(PORT_CFG_OFS, 8'h06, RESP_OKAY);
    // second reset in mid-run must bring every pin back to analog
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(ana.analog_mask), 32'hFF);
    rst_b <= 1'b1;
    rdchk(PORT_CFG_OFS, 8'h00);
    tally_and_finish();
  end
endmodule
